/* File: common/tmcc_pkg.sv */
// How it works
// - up mode: flag set on modulo-to-zero wrap
// - center mode: flag set leaving modulo downward
// - clear by read-while-set then write zero
// - writing one keeps flag; reset clears it
// - enable plus flag drives interrupt request
// - center select picks up or up/down
// - clock field picks none, bus, fixed, external
// - fixed and external clocks synchronised first
// - prescaler divides by two to the field
// - reading a counter byte freezes both bytes
// - reset, counter write, control write unfreeze
// - reset clears the counter
// - debug mode freezes counter and latch
// - at modulo restart at zero or turn down
// - half-written modulo inhibits the overflow flag
// - reset modulo zero means free running
// - up/down period is twice the modulo
// - control write discards pending modulo bytes
package tmcc_pkg;
    // ***********************************************
    // register map, byte registers in low bits of words
    // ***********************************************
    localparam logic [3:0] ADDR_SC       = 4'h0; // status/control
    localparam logic [3:0] ADDR_CNT_HIGH = 4'h4;
    localparam logic [3:0] ADDR_CNT_LOW  = 4'h8;
    localparam logic [3:0] ADDR_MOD_HIGH = 4'hc;
    localparam logic [3:0] ADDR_MOD_LOW  = 4'h0; // upper address bank, see addr bit
    localparam int ADDR_BANK_BIT = 4;             // address bit 4 picks bank 1
    // ***********************************************
    // status/control field positions
    // ***********************************************
    localparam int SC_FLAG_BIT   = 7;
    localparam int SC_IRQEN_BIT  = 6;
    localparam int SC_CENTER_BIT = 5;
    localparam int SC_CLK_MSB    = 4;
    localparam int SC_CLK_LSB    = 3;
    localparam int SC_PS_MSB     = 2;
    localparam int SC_PS_LSB     = 0;
    localparam logic [7:0] SC_RESET = 8'h00;
    // ***********************************************
    // clock source codes and reset values
    // ***********************************************
    localparam logic [1:0] CLK_NONE  = 2'h0;
    localparam logic [1:0] CLK_BUS   = 2'h1;
    localparam logic [1:0] CLK_FIXED = 2'h2;
    localparam logic [1:0] CLK_EXT   = 2'h3;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] MOD_RESET = 16'h0000;
endpackage : tmcc_pkg

/* File: src/tmcc_top.sv */
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module tmcc_top (
    input  wire logic        ref_clk,               // 20 MHz bus clock
    input  wire logic        rst_n,                 // async reset, active low
    input  wire logic [5:0]  avs_address,           // byte address
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        fixed_system_clock,    // asynchronous source
    input  wire logic        external_count_input,  // asynchronous source
    input  wire logic        debug_active,          // background debug mode
    output logic             overflow_irq,          // interrupt request level
    output logic      [15:0] counter_value,         // to channel logic
    output logic             overflow_pulse,        // one cycle per overflow
    output logic             count_down             // direction for channels
);
    // ***********************************************
    // state
    // ***********************************************
    typedef enum logic {TMCC_UP, TMCC_DOWN} tmcc_dir_t;
    logic [7:0]  sc_reg;            // control fields, flag kept apart
    logic        flag_reg;          // overflow flag
    logic        armed_reg;         // flag was read while set
    logic [15:0] cnt_reg;           // counter
    logic [15:0] mod_reg;           // active modulo
    logic [7:0]  mod_high_buf_reg;  // pending modulo bytes
    logic [7:0]  mod_low_buf_reg;
    logic        mod_high_got_reg;
    logic        mod_low_got_reg;
    logic [15:0] latch_reg;         // counter read buffer
    logic        latch_on_reg;
    tmcc_dir_t   dir_reg;
    logic [1:0]  fix_sync_reg;      // two-stage synchronisers
    logic [1:0]  ext_sync_reg;
    logic [1:0]  dbg_sync_reg;
    logic        fix_prev_reg;      // edge detect of synchronised levels
    logic        ext_prev_reg;
    logic [6:0]  ps_cnt_reg;        // prescaler
    logic        ack_reg;           // one wait state per access
    logic [31:0] rdata_reg;

    // ***********************************************
    // bus decode
    // ***********************************************
    logic        bank;
    logic [3:0]  off;
    logic        acc_take;          // access completes this cycle
    logic        wr_take;
    logic        rd_take;
    logic        wr_sc;
    logic        wr_cnt;
    logic        wr_mh;
    logic        wr_ml;
    logic        rd_sc;
    logic        rd_ch;
    logic        rd_cl;
    logic        wb0;               // low byte lane written
    localparam int ADDR_BANK_BIT_L = tmcc_pkg::ADDR_BANK_BIT;
    assign bank     = avs_address[ADDR_BANK_BIT_L];
    assign off      = avs_address[3:0];
    assign acc_take = (avs_read | avs_write) & ack_reg;
    assign wr_take  = avs_write & ack_reg;
    assign rd_take  = avs_read & ack_reg;
    assign wb0      = avs_byteenable[0];
    assign wr_sc  = wr_take & wb0 & !bank & (off == tmcc_pkg::ADDR_SC);
    assign wr_cnt = wr_take & wb0 & !bank &
                    ((off == tmcc_pkg::ADDR_CNT_HIGH) | (off == tmcc_pkg::ADDR_CNT_LOW));
    assign wr_mh  = wr_take & wb0 & !bank & (off == tmcc_pkg::ADDR_MOD_HIGH);
    assign wr_ml  = wr_take & wb0 & bank & (off == tmcc_pkg::ADDR_MOD_LOW);
    assign rd_sc  = rd_take & !bank & (off == tmcc_pkg::ADDR_SC);
    // counter reads act on the request edge, where read data is captured too,
    // so the latch holds exactly the count that the first byte came from
    assign rd_ch  = avs_read & !ack_reg & !bank & (off == tmcc_pkg::ADDR_CNT_HIGH);
    assign rd_cl  = avs_read & !ack_reg & !bank & (off == tmcc_pkg::ADDR_CNT_LOW);
    // waitrequest drops in the second cycle of every access
    assign avs_waitrequest = !ack_reg;

    // one wait state; cleared after completion so the next access waits again
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read | avs_write) & !ack_reg;
        end
    end

    // ***********************************************
    // clock source and prescaler
    // ***********************************************
    logic dbg;
    logic src_tick;
    logic tick;
    // synchronisers; stage 0 feeds only stage 1
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fix_sync_reg <= 2'h0;
            ext_sync_reg <= 2'h0;
            dbg_sync_reg <= 2'h0;
            fix_prev_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            fix_sync_reg <= {fix_sync_reg[0], fixed_system_clock};
            ext_sync_reg <= {ext_sync_reg[0], external_count_input};
            dbg_sync_reg <= {dbg_sync_reg[0], debug_active};
            fix_prev_reg <= fix_sync_reg[1];
            ext_prev_reg <= ext_sync_reg[1];
        end
    end
    assign dbg = dbg_sync_reg[1];

    // rising edges of slow sources become single-cycle ticks
    always_comb begin
        case (sc_reg[tmcc_pkg::SC_CLK_MSB:tmcc_pkg::SC_CLK_LSB])
            tmcc_pkg::CLK_BUS:   src_tick = 1'b1;
            tmcc_pkg::CLK_FIXED: src_tick = fix_sync_reg[1] & !fix_prev_reg;
            tmcc_pkg::CLK_EXT:   src_tick = ext_sync_reg[1] & !ext_prev_reg;
            default:             src_tick = 1'b0; // no clock, module idle
        endcase
    end

    // free prescaler; tick when the low ps bits all reach one
    logic [6:0] ps_mask;
    assign ps_mask = 7'(~(8'hff << sc_reg[tmcc_pkg::SC_PS_MSB:tmcc_pkg::SC_PS_LSB]));
    assign tick = src_tick & !dbg & ((ps_cnt_reg & ps_mask) == ps_mask);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ps_cnt_reg <= 7'h00;
        end else if (src_tick & !dbg) begin
            ps_cnt_reg <= ps_cnt_reg + 7'h01;
        end
    end

    // ***********************************************
    // counter and direction
    // ***********************************************
    logic center;
    logic at_mod;
    logic ovf_evt;
    assign center = sc_reg[tmcc_pkg::SC_CENTER_BIT];
    // modulo zero never matches in up mode so the counter wraps at ffff
    assign at_mod = (mod_reg != 16'h0000) & (cnt_reg == mod_reg);
    always_comb begin
        if (center) begin
            ovf_evt = tick & (dir_reg == TMCC_UP) & at_mod;
        end else begin
            ovf_evt = tick & (at_mod | ((mod_reg == 16'h0000) & (cnt_reg == 16'hffff)));
        end
    end

    // counter write resets count; debug holds via tick gating
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= tmcc_pkg::CNT_RESET;
            dir_reg <= TMCC_UP;
        end else if (wr_cnt) begin
            cnt_reg <= tmcc_pkg::CNT_RESET;
            dir_reg <= TMCC_UP;
        end else if (tick) begin
            if (!center) begin
                dir_reg <= TMCC_UP;
                cnt_reg <= at_mod ? 16'h0000 : cnt_reg + 16'h0001;
            end else if (dir_reg == TMCC_UP) begin
                if (at_mod) begin
                    dir_reg <= TMCC_DOWN;
                    cnt_reg <= cnt_reg - 16'h0001;
                end else begin
                    cnt_reg <= cnt_reg + 16'h0001;
                end
            end else begin
                if (cnt_reg == 16'h0001 || cnt_reg == 16'h0000) begin
                    dir_reg <= TMCC_UP;
                end
                cnt_reg <= (cnt_reg == 16'h0000) ? 16'h0001 : cnt_reg - 16'h0001;
            end
        end
    end

    // ***********************************************
    // overflow flag and control register
    // ***********************************************
    logic mod_pending;
    logic flag_set;
    assign mod_pending = mod_high_got_reg | mod_low_got_reg;
    assign flag_set    = ovf_evt & !mod_pending;

    // control fields; a write stores bits 6:0
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sc_reg <= tmcc_pkg::SC_RESET;
        end else if (wr_sc) begin
            sc_reg <= {1'b0, avs_writedata[6:0]};
        end
    end

    // set beats clear; a new event also drops the armed read
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_reg  <= 1'b0;
            armed_reg <= 1'b0;
        end else if (flag_set) begin
            flag_reg  <= 1'b1;
            armed_reg <= 1'b0;
        end else if (wr_sc) begin
            // writing one has no effect; zero clears only after an armed read
            if (!avs_writedata[tmcc_pkg::SC_FLAG_BIT] && armed_reg) begin
                flag_reg <= 1'b0;
            end
            armed_reg <= 1'b0;
        end else if (rd_sc && flag_reg) begin
            armed_reg <= 1'b1;
        end
    end

    assign overflow_irq = flag_reg & sc_reg[tmcc_pkg::SC_IRQEN_BIT];

    // ***********************************************
    // modulo byte coherency
    // ***********************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mod_reg          <= tmcc_pkg::MOD_RESET;
            mod_high_buf_reg <= 8'h00;
            mod_low_buf_reg  <= 8'h00;
            mod_high_got_reg <= 1'b0;
            mod_low_got_reg  <= 1'b0;
        end else if (wr_sc) begin
            mod_high_got_reg <= 1'b0;
            mod_low_got_reg  <= 1'b0;
        end else if (wr_mh && mod_low_got_reg) begin
            mod_reg          <= {avs_writedata[7:0], mod_low_buf_reg};
            mod_low_got_reg  <= 1'b0;
        end else if (wr_ml && mod_high_got_reg) begin
            mod_reg          <= {mod_high_buf_reg, avs_writedata[7:0]};
            mod_high_got_reg <= 1'b0;
        end else if (wr_mh) begin
            mod_high_buf_reg <= avs_writedata[7:0];
            mod_high_got_reg <= 1'b1;
        end else if (wr_ml) begin
            mod_low_buf_reg  <= avs_writedata[7:0];
            mod_low_got_reg  <= 1'b1;
        end
    end

    // ***********************************************
    // counter read latch
    // ***********************************************
    // latch on first byte read, release on the next counter byte read, either byte; debug freezes it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_reg    <= 16'h0000;
            latch_on_reg <= 1'b0;
        end else if (wr_cnt || wr_sc) begin
            latch_on_reg <= 1'b0;
        end else if (dbg) begin
            latch_on_reg <= latch_on_reg;
        end else if (rd_ch || rd_cl) begin
            if (!latch_on_reg) begin
                latch_reg    <= cnt_reg;
                latch_on_reg <= 1'b1;
            end else begin
                latch_on_reg <= 1'b0;
            end
        end
    end

    // read mux; unmapped reads return zero
    logic [15:0] cnt_view;
    assign cnt_view = latch_on_reg ? latch_reg : cnt_reg;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else if (avs_read & !ack_reg) begin
            case ({bank, off})
                {1'b0, tmcc_pkg::ADDR_SC}:       rdata_reg <= {24'h0, flag_reg, sc_reg[6:0]};
                {1'b0, tmcc_pkg::ADDR_CNT_HIGH}: rdata_reg <= {24'h0, cnt_view[15:8]};
                {1'b0, tmcc_pkg::ADDR_CNT_LOW}:  rdata_reg <= {24'h0, cnt_view[7:0]};
                {1'b0, tmcc_pkg::ADDR_MOD_HIGH}: rdata_reg <= {24'h0, mod_reg[15:8]};
                {1'b1, tmcc_pkg::ADDR_MOD_LOW}:  rdata_reg <= {24'h0, mod_reg[7:0]};
                default:                         rdata_reg <= 32'h0000_0000;
            endcase
        end
    end
    assign avs_readdata = rdata_reg;

    // ***********************************************
    // outputs to channel logic
    // ***********************************************
    logic ovf_q_reg;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ovf_q_reg <= 1'b0;
        end else begin
            ovf_q_reg <= ovf_evt;
        end
    end
    assign counter_value  = cnt_reg;
    assign overflow_pulse = ovf_q_reg;
    assign count_down     = (dir_reg == TMCC_DOWN);
endmodule : tmcc_top
`default_nettype wire

/* File: tb/tmcc_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port checks for the main counter section
// ****************************************
module tmcc_checker (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic [5:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        debug_active,
    input wire logic        overflow_irq,
    input wire logic [15:0] counter_value,
    input wire logic        overflow_pulse,
    input wire logic        count_down
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // debug held long enough to pass the two-stage synchroniser
    sequence s_dbg;
        debug_active [*4];
    endsequence
    // request parked in its single wait state
    sequence s_wait;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    wait_one_a: assert property (s_wait |=> !avs_waitrequest)
        else $error("access took more than one wait state");
    idle_wait_a: assert property (!(avs_read || avs_write) |-> avs_waitrequest)
        else $error("waitrequest low while idle");
    rd_upper_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    unmapped_a: assert property (avs_read && !avs_waitrequest && avs_address == 6'h14
        |-> avs_readdata == 32'h00000000) else $error("unmapped read not zero");
    cnt_reset_a: assert property ($rose(rst_n) |-> counter_value == 16'h0000)
        else $error("counter not zero after reset");
    // a counter write or a modulo wrap may clear to zero, any other change is one step
    cnt_step_a: assert property ($changed(counter_value) |-> counter_value == 16'h0000 ||
        counter_value == $past(counter_value) + 16'h0001 ||
        counter_value == $past(counter_value) - 16'h0001) else $error("counter jumped");
    debug_hold_a: assert property (s_dbg |=> $stable(counter_value))
        else $error("counter moved in debug");
    pulse_one_a: assert property (overflow_pulse |=> !overflow_pulse)
        else $error("overflow pulse longer than one cycle");
    up_wrap_a: assert property (overflow_pulse && !count_down |-> counter_value <= 16'h0001)
        else $error("up overflow away from zero");
    irq_cause_a: assert property ($rose(overflow_irq) && !$past(avs_write) &&
        !$past(overflow_pulse) |-> ##[0:2] overflow_pulse) else $error("irq without overflow");
    irq_clear_a: assert property ($fell(overflow_irq) |-> $past(avs_write))
        else $error("irq dropped without a write");
endmodule : tmcc_checker
bind tmcc_top tmcc_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .debug_active(debug_active), .overflow_irq(overflow_irq),
    .counter_value(counter_value), .overflow_pulse(overflow_pulse), .count_down(count_down));
`default_nettype wire

/* File: tb/tmcc_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module tmcc_top_test;
    // ****************************
    // stimulus, outputs and scores
    // ****************************
    localparam logic [5:0] A_SC = 6'h00, A_CH = 6'h04, A_CL = 6'h08, A_MH = 6'h0c, A_ML = 6'h10;
    logic        ref_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic        debug_active = 1'b0, fixed_system_clock = 1'b0, external_count_input = 1'b0;
    logic [5:0]  avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h00000000, avs_readdata;
    logic        avs_waitrequest, overflow_irq, overflow_pulse, count_down, dn;
    logic [15:0] counter_value, cp, mx, cv;   // count at pulse, max, snapshot
    logic [7:0]  rq, hb;                      // last read byte, first byte
    int          error_cnt = 0, checked = 0, cyc = 0, p;
    tmcc_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .fixed_system_clock(fixed_system_clock), .external_count_input(external_count_input),
        .debug_active(debug_active), .overflow_irq(overflow_irq),
        .counter_value(counter_value), .overflow_pulse(overflow_pulse), .count_down(count_down));
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    // slow sources: fixed rises every 8 cycles, external every 16, both under a quarter rate
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        fixed_system_clock <= cyc[2];
        external_count_input <= cyc[3];
        if (cyc == 30000) begin  // hang guard, run needs about 6k cycles
            error_cnt++;
            finish_test();
        end
    end
    task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // one bus access, held until waitrequest is seen low; read byte lands in rq
    task acc(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        rq = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : acc
    task wp();
        int n;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (overflow_pulse !== 1'b1 && n < 3000);
    endtask : wp
    // cycles between two pulses, with peak count and direction seen
    task meas();
        wp();  // skip a wrap that may still belong to the old setting
        wp();
        cp = counter_value;
        mx = 16'h0000;
        dn = 1'b0;
        p = 0;
        do begin
            @(negedge ref_clk);
            p++;
            if (counter_value > mx) mx = counter_value;
            dn |= count_down;
        end while (overflow_pulse !== 1'b1 && p < 3000);
    endtask : meas
    // ****************************
    // scenarios
    // ****************************
    task t_reset();
        for (int i = 0; i < 6; i++) begin  // last address is unmapped
            acc(1'b0, 6'(i * 4), 8'h00);
            chk("reset read", {8'h00, rq}, 16'h0000);
        end
        repeat (20) @(negedge ref_clk);
        chk("no source", counter_value, 16'h0000);
    endtask : t_reset
    task t_prescale();
        acc(1'b1, A_SC, 8'h00);  // clock off while the modulo loads, so the count stays below it
        acc(1'b1, A_MH, 8'h00);
        acc(1'b1, A_ML, 8'h03);
        for (int ps = 0; ps < 8; ps++) begin
            acc(1'b1, A_SC, 8'h08 | 8'(ps));
            meas();
            chk("period", 16'(p), 16'(4 << ps));
            chk("up max", mx, 16'h0003);
            chk("wrap count", {15'h0000, cp <= 16'h0001}, 16'h0001);
        end
        acc(1'b0, A_SC, 8'h00);
        chk("flag set", {8'h00, rq}, 16'h008f);
    endtask : t_prescale
    task t_flag();
        wp();  // start just after an overflow so no new one races the steps
        acc(1'b1, A_SC, 8'hcf);
        @(negedge ref_clk);
        chk("irq on", {15'h0000, overflow_irq}, 16'h0001);
        acc(1'b0, A_SC, 8'h00);
        chk("one kept", {8'h00, rq}, 16'h00cf);
        acc(1'b1, A_SC, 8'h4f);
        @(negedge ref_clk);
        chk("irq off", {15'h0000, overflow_irq}, 16'h0000);
        acc(1'b0, A_SC, 8'h00);
        chk("cleared", {8'h00, rq}, 16'h004f);
        wp();
        acc(1'b0, A_SC, 8'h00);
        wp();  // new overflow between read and write
        acc(1'b1, A_SC, 8'h4f);
        acc(1'b0, A_SC, 8'h00);
        chk("race kept", {8'h00, rq}, 16'h00cf);
        acc(1'b1, A_SC, 8'h8f);
        @(negedge ref_clk);
        chk("polled only", {15'h0000, overflow_irq}, 16'h0000);
    endtask : t_flag
    task t_modulo();
        acc(1'b0, A_SC, 8'h00);  // arm the clear; the last wrap was only moments ago
        acc(1'b1, A_CL, 8'h00);  // restart the count before touching the modulo
        acc(1'b1, A_SC, 8'h0b);  // clears the flag; divide by 8 keeps the next wrap off
        acc(1'b1, A_MH, 8'h00);  // half written, old limit still wraps
        p = 0;
        repeat (80) begin
            @(negedge ref_clk);
            p += int'(overflow_pulse);
        end
        chk("wraps seen", {15'h0000, p > 0}, 16'h0001);
        acc(1'b0, A_SC, 8'h00);
        chk("inhibit", {8'h00, rq}, 16'h000b);
        acc(1'b1, A_ML, 8'h07);
        acc(1'b1, A_SC, 8'h08);
        meas();
        chk("new limit", 16'(p), 16'h0008);
        acc(1'b1, A_MH, 8'h12);
        acc(1'b1, A_SC, 8'h08);
        acc(1'b1, A_ML, 8'h03);
        acc(1'b1, A_MH, 8'h00);
        acc(1'b1, A_CL, 8'h00);  // count may sit above the new limit; restart it
        meas();
        chk("discard", 16'(p), 16'h0004);
        acc(1'b0, A_ML, 8'h00);
        chk("mod low", {8'h00, rq}, 16'h0003);
    endtask : t_modulo
    task t_source();
        for (int s = 2; s < 4; s++) begin  // fixed then external
            acc(1'b1, A_SC, 8'(s << 3));
            meas();
            chk("source period", 16'(p), 16'(8 << s));
        end
        acc(1'b1, A_SC, 8'h00);
        @(negedge ref_clk);
        cv = counter_value;
        repeat (50) @(negedge ref_clk);
        chk("disabled", counter_value, cv);
    endtask : t_source
    task t_latch();
        acc(1'b1, A_SC, 8'h08);
        acc(1'b1, A_MH, 8'h00);
        acc(1'b1, A_ML, 8'h00);
        for (int o = 0; o < 3; o++) begin  // low first, high first, release by control write
            if (o == 2) begin
                acc(1'b0, A_CH, 8'h00);
                acc(1'b1, A_SC, 8'h08);
            end
            @(negedge ref_clk);
            cv = counter_value;
            acc(1'b0, (o == 1) ? A_CH : A_CL, 8'h00);
            hb = rq;
            repeat (300) @(negedge ref_clk);
            acc(1'b0, (o == 1) ? A_CL : A_CH, 8'h00);
            cp = ((o == 1) ? {hb, rq} : {rq, hb}) - cv;
            chk("coherent", {15'h0000, cp <= 16'h0006}, 16'h0001);
        end
        debug_active <= 1'b1;
        repeat (4) @(negedge ref_clk);
        cv = counter_value;
        acc(1'b0, A_CL, 8'h00);
        hb = rq;
        acc(1'b0, A_CH, 8'h00);
        chk("debug read", {rq, hb}, cv);
        chk("debug hold", counter_value, cv);
        debug_active <= 1'b0;
    endtask : t_latch
    task t_center();
        acc(1'b1, A_SC, 8'h2f);  // centre mode at the slowest rate while the modulo loads
        acc(1'b1, A_CL, 8'h00);  // restart from zero before the modulo write
        acc(1'b1, A_MH, 8'h00);
        acc(1'b1, A_ML, 8'h05);
        acc(1'b1, A_SC, 8'h28);
        meas();
        chk("updown period", 16'(p), 16'h000a);
        chk("updown peak", mx, 16'h0005);
        chk("went down", {15'h0000, dn}, 16'h0001);
        chk("flag on turn", {15'h0000, cp == 16'h0004 || cp == 16'h0003}, 16'h0001);
    endtask : t_center
    task finish_test();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_prescale();
        t_flag();
        t_modulo();
        t_source();
        t_latch();
        t_center();
        finish_test();
    end
endmodule : tmcc_top_test
`default_nettype wire
